// ### logic/clock_source_control_regs.sv
// Clock source control registers with loop, references and outputs
//
// The AHB-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
// Behaviour
// RL1 - Source code 11 acts as 00
// RL2 - 00 loop, 01 internal, 10 external source
// RL3 - Reference divided by two to the code
// RL4 - Software keeps divided reference within limits
// RL5 - Reference select picks internal or external reference
// RL6 - Internal reference output follows its enable
// RL7 - Internal reference kept in stop when allowed
// RL8 - Bus divider divides by 1,2,4,8
// RL9 - Range bit drives oscillator range
// RL10 - Gain bit drives oscillator gain
// RL11 - Low power disables loop when bypassed
// RL12 - Source bit requests crystal or clock
// RL13 - External reference output follows its enable
// RL14 - External reference kept in stop when allowed
// RL15 - No package pins, all internal
// RL16 - Loop runs at 512 times divided reference
// RL17 - System clock twice the bus clock
// RL18 - Glitch-free switching of source and divider
module clock_source_control_regs
  import clkgen_pkg::*;
#(
  parameter int PERIOD_W = 16
) (
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic HREADY_I,
  input wire logic [31:0] HWDATA_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  input wire logic INT_REF_I,
  input wire logic EXT_REF_I,
  input wire logic STOP_I,
  input wire logic BACKGROUND_DEBUG_ACTIVE_I,
  output logic SYSTEM_CLOCK_OUT_O,
  output logic BUS_CLOCK_O,
  output logic INTERNAL_REF_CLOCK_OUT_O,
  output logic EXTERNAL_REF_CLOCK_OUT_O,
  output logic LOOP_ENABLE_O,
  output logic INT_REF_RUN_O,
  output logic EXT_REF_RUN_O,
  output logic OSC_HIGH_RANGE_O,
  output logic OSC_HIGH_GAIN_O,
  output logic OSC_CRYSTAL_O
);

  // All ports are on-chip nets; nothing here reaches a package pin
  // (RL15 holds by construction).

  logic [7:0] ctrl_one_reg;
  logic [7:0] ctrl_one_next;
  logic [7:0] ctrl_two_reg;
  logic [7:0] ctrl_two_next;
  logic wr_pend_reg;
  logic [ADDR_W-1:0] wr_addr_reg;
  logic [31:0] hrdata_reg;
  logic hreadyout_reg;
  logic [1:0] sync1_reg;
  logic [1:0] sync2_reg;
  logic [1:0] sync3_reg;
  logic [1:0] level_reg;
  logic [1:0] prev_reg;
  logic [1:0] edge_vec;
  logic [1:0] rise_vec;
  logic ref_rise;
  logic [6:0] ref_cnt_reg;
  logic div_pulse_reg;
  logic [PERIOD_W-1:0] per_cnt_reg;
  logic [PERIOD_W-1:0] period_reg;
  logic [PERIOD_W-1:0] loop_cnt_reg;
  logic loop_tick_reg;
  mode_t mode_reg;
  logic int_mode;
  logic ext_mode;
  logic low_power_mode;
  logic int_before_reg;
  logic ext_before_reg;
  logic int_run;
  logic ext_run;
  logic loop_en_reg;
  logic int_run_reg;
  logic ext_run_reg;
  logic int_out_reg;
  logic ext_out_reg;
  logic range_reg;
  logic gain_reg;
  logic xtal_reg;
  logic accept;
  logic [31:0] status;
  logic [ADDR_W-1:0] rd_addr;
  clk_path_if path ();

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Mode from source, reference select, low power and debug state
  function automatic mode_t mode_of(input logic [1:0] src,
                                    input logic iref, input logic lp,
                                    input logic background_debug_active);
    logic lowp;
    lowp = lp && !background_debug_active; // RL11
    if (src == SRC_INT) begin
      return lowp ? BYP_INT_LP : BYP_INT;
    end
    if (src == SRC_EXT) begin
      return lowp ? BYP_EXT_LP : BYP_EXT;
    end
    return iref ? ENG_INT : ENG_EXT;
  endfunction

  // Half period of the loop in system cycles, never below one
  function automatic logic [PERIOD_W-1:0] loop_interval(
      input logic [PERIOD_W-1:0] per);
    logic [PERIOD_W-1:0] half;
    half = per >> LOOP_EDGE_SHIFT;
    return (half == '0) ? PERIOD_W'(1) : half;
  endfunction

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  assign accept = HSEL_I && HTRANS_I[1] && HREADY_I;
  assign rd_addr = HADDR_I[ADDR_W-1:0];

  // Address phase of a write, completed in the next cycle
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
    end else begin
      wr_pend_reg <= accept && HWRITE_I;
      wr_addr_reg <= rd_addr;
    end
  end

  // Data phase writes; reserved source code is stored as 00
  always_comb begin
    ctrl_one_next = ctrl_one_reg;
    ctrl_two_next = ctrl_two_reg;
    if (wr_pend_reg && wr_addr_reg == CTRL_ONE_ADDR) begin
      ctrl_one_next = HWDATA_I[7:0];
      if (HWDATA_I[SRC_SEL_HI:SRC_SEL_LO] == SRC_RSVD) begin
        ctrl_one_next[SRC_SEL_HI:SRC_SEL_LO] = SRC_LOOP; // RL1
      end
    end
    if (wr_pend_reg && wr_addr_reg == CTRL_TWO_ADDR) begin
      ctrl_two_next = HWDATA_I[7:0];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      ctrl_one_reg <= CTRL_ONE_RESET;
      ctrl_two_reg <= CTRL_TWO_RESET;
    end else begin
      ctrl_one_reg <= ctrl_one_next;
      ctrl_two_reg <= ctrl_two_next;
    end
  end

  assign status = {21'h00_0000, ext_run_reg, int_run_reg, loop_en_reg,
                   path.active_sel, mode_reg};

  // Read data from next values so a write then read is coherent
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      hrdata_reg <= 32'h0000_0000;
      hreadyout_reg <= 1'b0;
    end else begin
      hreadyout_reg <= 1'b1;
      if (accept && !HWRITE_I) begin
        unique case (rd_addr)
          CTRL_ONE_ADDR: hrdata_reg <= {24'h00_0000, ctrl_one_next};
          CTRL_TWO_ADDR: hrdata_reg <= {24'h00_0000, ctrl_two_next};
          STATUS_ADDR: hrdata_reg <= status;
          default: hrdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************************************
  // Reference inputs
  // ****************************************************************

  // Three stages; level moves only when stages two and three agree
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      sync1_reg <= 2'h0;
      sync2_reg <= 2'h0;
      sync3_reg <= 2'h0;
      level_reg <= 2'h0;
      prev_reg <= 2'h0;
    end else begin
      sync1_reg <= {EXT_REF_I, INT_REF_I};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      level_reg <= (~(sync2_reg ^ sync3_reg) & sync3_reg)
                 | ((sync2_reg ^ sync3_reg) & level_reg);
      prev_reg <= level_reg;
    end
  end

  assign edge_vec = level_reg ^ prev_reg;
  assign rise_vec = level_reg & ~prev_reg;
  assign ref_rise = ctrl_one_reg[REF_SEL_BIT] ? rise_vec[IDX_INT]
                                              : rise_vec[IDX_EXT]; // RL5

  // Divide the loop reference by 2^code
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      ref_cnt_reg <= 7'h00;
      div_pulse_reg <= 1'b0;
    end else begin
      div_pulse_reg <= 1'b0;
      if (ref_rise) begin
        if (ref_cnt_reg >= 7'((8'h01 <<
            ctrl_one_reg[REF_DIV_HI:REF_DIV_LO]) - 8'h01)) begin // RL3
          ref_cnt_reg <= 7'h00;
          div_pulse_reg <= 1'b1;
        end else begin
          ref_cnt_reg <= ref_cnt_reg + 7'h01;
        end
      end
    end
  end

  // ****************************************************************
  // Locked loop model
  // ****************************************************************

  // Measure the divided reference period; saturates if it stalls
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      per_cnt_reg <= '0;
      period_reg <= '0;
    end else if (div_pulse_reg) begin
      period_reg <= per_cnt_reg;
      per_cnt_reg <= PERIOD_W'(1);
    end else if (per_cnt_reg != '1) begin
      per_cnt_reg <= per_cnt_reg + PERIOD_W'(1);
    end
  end

  // Locks at once to 512x; no lock transient is modelled
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      loop_cnt_reg <= '0;
      loop_tick_reg <= 1'b0;
    end else if (!loop_en_reg || period_reg == '0) begin
      loop_cnt_reg <= '0;
      loop_tick_reg <= 1'b0;
    end else if (loop_cnt_reg + PERIOD_W'(1)
                 >= loop_interval(period_reg)) begin // RL16
      loop_cnt_reg <= '0;
      loop_tick_reg <= 1'b1;
    end else begin
      loop_cnt_reg <= loop_cnt_reg + PERIOD_W'(1);
      loop_tick_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Mode and stop control
  // ****************************************************************
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      mode_reg <= ENG_INT;
    end else begin
      mode_reg <= mode_of(ctrl_one_reg[SRC_SEL_HI:SRC_SEL_LO], // RL2
                          ctrl_one_reg[REF_SEL_BIT],
                          ctrl_two_reg[LOW_POWER_BIT],
                          BACKGROUND_DEBUG_ACTIVE_I);
    end
  end

  always_comb begin
    int_mode = 1'b0;
    ext_mode = 1'b0;
    low_power_mode = 1'b0;
    unique case (mode_reg)
      ENG_INT, BYP_INT: int_mode = 1'b1;
      BYP_INT_LP: begin
        int_mode = 1'b1;
        low_power_mode = 1'b1; // RL11
      end
      ENG_EXT, BYP_EXT: ext_mode = 1'b1;
      BYP_EXT_LP: begin
        ext_mode = 1'b1;
        low_power_mode = 1'b1; // RL11
      end
    endcase
  end

  // Mode held from before stop decides what survives the stop
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      int_before_reg <= 1'b1;
      ext_before_reg <= 1'b0;
    end else if (!STOP_I) begin
      int_before_reg <= int_mode;
      ext_before_reg <= ext_mode;
    end
  end

  assign int_run = STOP_I
    ? (ctrl_one_reg[IREF_KEEP_BIT]
       && (ctrl_one_reg[IREF_OUT_BIT] || int_before_reg)) // RL7
    : (ctrl_one_reg[IREF_OUT_BIT] || int_mode);
  assign ext_run = STOP_I
    ? (ctrl_two_reg[EREF_KEEP_BIT]
       && (ctrl_two_reg[EREF_OUT_BIT] || ext_before_reg)) // RL14
    : (ctrl_two_reg[EREF_OUT_BIT] || ext_mode);

  // Registered enables and clock outputs
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      loop_en_reg <= 1'b1;
      int_run_reg <= 1'b1;
      ext_run_reg <= 1'b0;
      int_out_reg <= 1'b0;
      ext_out_reg <= 1'b0;
    end else begin
      loop_en_reg <= !STOP_I && !low_power_mode; // RL11
      int_run_reg <= int_run;
      ext_run_reg <= ext_run;
      int_out_reg <= level_reg[IDX_INT] && int_run
                   && ctrl_one_reg[IREF_OUT_BIT]; // RL6
      ext_out_reg <= level_reg[IDX_EXT] && ext_run
                   && ctrl_two_reg[EREF_OUT_BIT]; // RL13
    end
  end

  // Oscillator controls, registered so the outputs are clean
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      range_reg <= CTRL_TWO_RESET[RANGE_BIT];
      gain_reg <= CTRL_TWO_RESET[GAIN_BIT];
      xtal_reg <= CTRL_TWO_RESET[XTAL_BIT];
    end else begin
      range_reg <= ctrl_two_reg[RANGE_BIT]; // RL9
      gain_reg <= ctrl_two_reg[GAIN_BIT]; // RL10
      xtal_reg <= ctrl_two_reg[XTAL_BIT]; // RL12
    end
  end

  // ****************************************************************
  // Output clock stage
  // ****************************************************************
  assign path.loop_tick = loop_tick_reg;
  assign path.int_tick = edge_vec[IDX_INT];
  assign path.ext_tick = edge_vec[IDX_EXT];
  assign path.src_sel = ctrl_one_reg[SRC_SEL_HI:SRC_SEL_LO]; // RL2
  assign path.bus_div = ctrl_two_reg[BUS_DIV_HI:BUS_DIV_LO]; // RL8
  assign path.run = !STOP_I; // No system clock in stop

  clock_output_stage u_stage (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .path(path)
  );

  assign HRDATA_O = hrdata_reg;
  assign HREADYOUT_O = hreadyout_reg;
  assign HRESP_O = 1'b0;
  assign SYSTEM_CLOCK_OUT_O = path.sys_clk;
  assign BUS_CLOCK_O = path.bus_clk;
  assign INTERNAL_REF_CLOCK_OUT_O = int_out_reg;
  assign EXTERNAL_REF_CLOCK_OUT_O = ext_out_reg;
  assign LOOP_ENABLE_O = loop_en_reg;
  assign INT_REF_RUN_O = int_run_reg;
  assign EXT_REF_RUN_O = ext_run_reg;
  assign OSC_HIGH_RANGE_O = range_reg;
  assign OSC_HIGH_GAIN_O = gain_reg;
  assign OSC_CRYSTAL_O = xtal_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  rsvd_code_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    ctrl_one_reg[SRC_SEL_HI:SRC_SEL_LO] != SRC_RSVD) // RL1
    else $error("Reserved source code stored");
  mode_map_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    ctrl_one_reg[SRC_SEL_HI:SRC_SEL_LO] == SRC_EXT
    |=> mode_reg inside {BYP_EXT, BYP_EXT_LP}) // RL2
    else $error("External source did not give a bypass external mode");
  ref_div_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (ref_rise && ctrl_one_reg[REF_DIV_HI:REF_DIV_LO] == 3'h0)
    |=> div_pulse_reg) // RL3
    else $error("Divide by one missed a reference edge");
  iref_out_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    !ctrl_one_reg[IREF_OUT_BIT] |=> !INTERNAL_REF_CLOCK_OUT_O) // RL6
    else $error("Internal reference output active while disabled");
  iref_stop_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (STOP_I && !ctrl_one_reg[IREF_KEEP_BIT]) |=> !INT_REF_RUN_O) // RL7
    else $error("Internal reference ran in stop");
  loop_lp_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (mode_reg == BYP_INT_LP) |=> !LOOP_ENABLE_O) // RL11
    else $error("Loop enabled in low power bypass");
  eref_out_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    !ctrl_two_reg[EREF_OUT_BIT] |=> !EXTERNAL_REF_CLOCK_OUT_O) // RL13
    else $error("External reference output active while disabled");
  eref_stop_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (STOP_I && ctrl_two_reg[EREF_KEEP_BIT] && ctrl_two_reg[EREF_OUT_BIT])
    |=> EXT_REF_RUN_O) // RL14
    else $error("External reference stopped though kept");
  stop_keep_c: cover property (@(posedge CLK_I) disable iff (SYS_RST_I)
    STOP_I && INT_REF_RUN_O);
  loop_run_c: cover property (@(posedge CLK_I) disable iff (SYS_RST_I)
    loop_tick_reg && mode_reg == ENG_INT);
  byp_ext_c: cover property (@(posedge CLK_I) disable iff (SYS_RST_I)
    mode_reg == BYP_EXT_LP);

endmodule // clock_source_control_regs

// ### logic/clkgen_pkg.sv
// Constants and types shared by the clock source control block
package clkgen_pkg;

  // ****************************************************************
  // Register map on the bus
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_ONE_ADDR = 8'h00;
  localparam logic [ADDR_W-1:0] CTRL_TWO_ADDR = 8'h04;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h08;
  localparam logic [7:0] CTRL_ONE_RESET = 8'h04;
  localparam logic [7:0] CTRL_TWO_RESET = 8'h40;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int SRC_SEL_HI = 7;
  localparam int SRC_SEL_LO = 6;
  localparam int REF_DIV_HI = 5;
  localparam int REF_DIV_LO = 3;
  localparam int REF_SEL_BIT = 2;
  localparam int IREF_OUT_BIT = 1;
  localparam int IREF_KEEP_BIT = 0;
  localparam int BUS_DIV_HI = 7;
  localparam int BUS_DIV_LO = 6;
  localparam int RANGE_BIT = 5;
  localparam int GAIN_BIT = 4;
  localparam int LOW_POWER_BIT = 3;
  localparam int XTAL_BIT = 2;
  localparam int EREF_OUT_BIT = 1;
  localparam int EREF_KEEP_BIT = 0;

  // ****************************************************************
  // Codes and timing
  // ****************************************************************
  localparam logic [1:0] SRC_LOOP = 2'h0;
  localparam logic [1:0] SRC_INT = 2'h1;
  localparam logic [1:0] SRC_EXT = 2'h2;
  localparam logic [1:0] SRC_RSVD = 2'h3;
  localparam int IDX_INT = 0;
  localparam int IDX_EXT = 1;
  // Loop runs 512 periods per reference period, two edges per period
  localparam int LOOP_EDGE_SHIFT = 10;

  typedef enum logic [5:0] {
    ENG_INT = 6'b00_0001,
    ENG_EXT = 6'b00_0010,
    BYP_INT = 6'b00_0100,
    BYP_INT_LP = 6'b00_1000,
    BYP_EXT = 6'b01_0000,
    BYP_EXT_LP = 6'b10_0000
  } mode_t;

endpackage

// ### logic/clk_path_if.sv
// Tick sources and selections passed to the output clock stage
`timescale 1ns/1ps
interface clk_path_if;
  logic loop_tick;
  logic int_tick;
  logic ext_tick;
  logic [1:0] src_sel;
  logic [1:0] bus_div;
  logic run;
  logic sys_clk;
  logic bus_clk;
  logic [1:0] active_sel;
  modport ctrl (
    output loop_tick, int_tick, ext_tick, src_sel, bus_div, run,
    input sys_clk, bus_clk, active_sel
  );
  modport stage (
    input loop_tick, int_tick, ext_tick, src_sel, bus_div, run,
    output sys_clk, bus_clk, active_sel
  );
endinterface

// ### logic/clock_output_stage.sv
// Glitch-free source switch, bus divider and system clock output
`timescale 1ns/1ps
module clock_output_stage
  import clkgen_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  clk_path_if.stage path
);

  logic [1:0] active_sel_reg;
  logic [1:0] active_div_reg;
  logic [2:0] cnt_reg;
  logic sys_clk_reg;
  logic bus_clk_reg;
  logic tick;
  logic toggle;
  logic switch_now;

  // Terminal count of the divider: 2^code - 1
  function automatic logic [2:0] div_limit(input logic [1:0] code);
    return 3'((4'h1 << code) - 4'h1);
  endfunction

  // Edge events of the selected source, one per half period
  always_comb begin
    unique case (active_sel_reg)
      SRC_INT: tick = path.int_tick;
      SRC_EXT: tick = path.ext_tick;
      default: tick = path.loop_tick;
    endcase
  end

  assign toggle = tick && path.run && (cnt_reg == div_limit(active_div_reg));

  // Pending change, taken in the low phase at a count boundary; the
  // count restarts so a tick on that edge cannot skew the new divider
  assign switch_now = !sys_clk_reg && cnt_reg == 3'h0
    && (path.src_sel != active_sel_reg || path.bus_div != active_div_reg);

  // Switch only in the low phase at a count boundary, so no runt
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_sel_reg <= SRC_LOOP;
      active_div_reg <= CTRL_TWO_RESET[BUS_DIV_HI:BUS_DIV_LO];
    end else if (switch_now) begin // RL18
      active_sel_reg <= path.src_sel;
      active_div_reg <= path.bus_div;
    end
  end

  // Divide the source edges, stopped while the unit is in stop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= 3'h0;
      sys_clk_reg <= 1'b0;
      bus_clk_reg <= 1'b0;
    end else if (tick && path.run) begin
      cnt_reg <= (toggle || switch_now) ? 3'h0 : cnt_reg + 3'h1; // RL8
      if (toggle) begin
        sys_clk_reg <= !sys_clk_reg;
        if (!sys_clk_reg) begin
          bus_clk_reg <= !bus_clk_reg; // RL17
        end
      end
    end
  end

  assign path.sys_clk = sys_clk_reg;
  assign path.bus_clk = bus_clk_reg;
  assign path.active_sel = active_sel_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sel_switch_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL18
    $changed(active_sel_reg) |-> $past(!sys_clk_reg))
    else $error("Source switched in high phase");
  bus_half_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL17
    $changed(bus_clk_reg) |-> $rose(sys_clk_reg))
    else $error("Bus clock moved off a system rising edge");
  div_one_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL8
    (active_div_reg == 2'h0 && tick && path.run) |=> $changed(sys_clk_reg))
    else $error("Divide by one missed an edge");
  switch_c: cover property (@(posedge clk_i) disable iff (rst_i)
    $changed(active_sel_reg));

endmodule // clock_output_stage

// ### tb/clock_source_control_regs_tb.sv
// Self-checking bench for the clock source control registers
`timescale 1ns/1ps
module clock_source_control_regs_tb;
  import clkgen_pkg::*;
  // ***********
  // Signals
  // ***********
  logic CLK_I = 0, SYS_RST_I = 1, HSEL_I = 0, HWRITE_I = 0, HREADY_I;
  logic [31:0] HADDR_I = 0, HWDATA_I = 0, HRDATA_O;
  logic [1:0] HTRANS_I = 0;
  logic [2:0] HSIZE_I = 3'h2;
  logic INT_REF_I = 0, EXT_REF_I = 0, STOP_I = 0, DBG_I = 0;
  logic HREADYOUT_O, HRESP_O, SYS_O, BUS_O, IREF_O, EREF_O, LOOP_O;
  logic IRUN_O, ERUN_O, RANGE_O, GAIN_O, XTAL_O;
  logic ref_run = 0, ref_lvl = 0;
  logic [1:0] ref_cnt = 0;
  int err_count = 0, n_checks = 0;
  localparam logic [31:0] STOP_C1 = 32'h0105_0407;
  localparam logic [31:0] STOP_C2 = 32'h4140_4143;
  localparam logic [3:0] STOP_INT = 4'b0101;
  localparam logic [3:0] STOP_EXT = 4'b1001;

  // Single slave, so its ready is the bus ready
  assign HREADY_I = HREADYOUT_O;

  clock_source_control_regs dut (
    .CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .HSEL_I(HSEL_I),
    .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I),
    .HSIZE_I(HSIZE_I), .HREADY_I(HREADY_I), .HWDATA_I(HWDATA_I),
    .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
    .INT_REF_I(INT_REF_I), .EXT_REF_I(EXT_REF_I), .STOP_I(STOP_I),
    .BACKGROUND_DEBUG_ACTIVE_I(DBG_I), .SYSTEM_CLOCK_OUT_O(SYS_O),
    .BUS_CLOCK_O(BUS_O), .INTERNAL_REF_CLOCK_OUT_O(IREF_O),
    .EXTERNAL_REF_CLOCK_OUT_O(EREF_O), .LOOP_ENABLE_O(LOOP_O),
    .INT_REF_RUN_O(IRUN_O), .EXT_REF_RUN_O(ERUN_O),
    .OSC_HIGH_RANGE_O(RANGE_O), .OSC_HIGH_GAIN_O(GAIN_O),
    .OSC_CRYSTAL_O(XTAL_O));

  always #5 CLK_I = ~CLK_I;

  // Internal reference: toggles every 4 cycles, or a static level
  always @(posedge CLK_I) begin
    ref_cnt <= ref_cnt + 2'h1;
    if (!ref_run) INT_REF_I <= ref_lvl;
    else if (ref_cnt == 2'h3) INT_REF_I <= ~INT_REF_I;
  end

  // ***********
  // Tasks
  // ***********
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %0t ns saw %h expected %h", $time, s, e);
    end
  endtask

  task automatic chb(input logic s, input logic e);
    chk({31'h0, s}, {31'h0, e});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge CLK_I);
  endtask

  // Bounded wait for ready; a hang ends the run
  task automatic wait_rdy();
    int i;
    i = 0;
    do begin
      @(posedge CLK_I);
      i++;
    end while (HREADYOUT_O !== 1'b1 && i < 64);
    if (i >= 64) begin
      err_count++;
      $display("[FAIL] %0t ns bus timeout", $time);
      final_report();
    end
  endtask

  // One single word transfer, read data taken at the data phase edge
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    HSEL_I <= 1'b1;
    HTRANS_I <= 2'h2;
    HWRITE_I <= w;
    HADDR_I <= {24'h0, a};
    wait_rdy();
    HSEL_I <= 1'b0;
    HTRANS_I <= 2'h0;
    HWDATA_I <= d;
    wait_rdy();
    r = HRDATA_O;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask

  task automatic done(input string s);
    $display("test %s done at %0t ns", s, $time);
  endtask

  // Reserved source code reads back as the loop code
  function automatic logic [31:0] exp_one(input logic [31:0] d);
    return {24'h0, (d[7:6] == 2'h3) ? 2'h0 : d[7:6], d[5:0]};
  endfunction

  function automatic logic near(input int a, input int b);
    return (a - b <= 2) && (b - a <= 2);
  endfunction

  // ***********
  // Sequence
  // ***********
  initial begin
    logic [31:0] d;
    logic ps, pb;
    int st, bt;
    void'($urandom(32'h712cbd4c));
    cyc(4);
    SYS_RST_I <= 1'b0;
    rdc(CTRL_ONE_ADDR, 32'h0000_0004);
    rdc(CTRL_TWO_ADDR, 32'h0000_0040);
    chb(HRESP_O, 1'b0);
    done("reset");
    // Internal source, every divider code, counted over 128 ref edges
    ref_run <= 1'b1;
    wr(CTRL_ONE_ADDR, 32'h0000_0044);
    for (int k = 0; k < 4; k++) begin
      wr(CTRL_TWO_ADDR, {24'h0, k[1:0], 6'h0});
      cyc(40);
      st = 0;
      bt = 0;
      ps = SYS_O;
      pb = BUS_O;
      repeat (512) begin
        @(posedge CLK_I);
        if (SYS_O !== ps) st++;
        if (BUS_O !== pb) bt++;
        ps = SYS_O;
        pb = BUS_O;
      end
      chb(near(st, 128 >> k), 1'b1);
      chb(near(bt, st / 2), 1'b1);
    end
    ref_run <= 1'b0;
    done("divider");
    // Random register contents, reserved source code among them
    for (int k = 0; k < 6; k++) begin
      d = $urandom;
      wr(CTRL_TWO_ADDR, d);
      rdc(CTRL_TWO_ADDR, {24'h0, d[7:0]});
      cyc(4);
      chb(RANGE_O, d[5]);
      chb(GAIN_O, d[4]);
      chb(XTAL_O, d[2]);
      d = $urandom;
      if (k < 2) d[7:6] = 2'h3;
      wr(CTRL_ONE_ADDR, d);
      rdc(CTRL_ONE_ADDR, exp_one(d));
    end
    rdc(8'h0c, 32'h0);
    done("registers");
    // Reference outputs follow enable and reference level
    for (int k = 0; k < 4; k++) begin
      wr(CTRL_ONE_ADDR, {29'h0, 1'b1, k[0], 1'b0});
      wr(CTRL_TWO_ADDR, {24'h0, 6'h10, k[0], 1'b0});
      ref_lvl <= k[1];
      EXT_REF_I <= k[1];
      cyc(10);
      chb(IREF_O, k[0] & k[1]);
      chb(EREF_O, k[0] & k[1]);
    end
    done("enables");
    // Low power in bypass, debug override, engaged and external cases
    for (int k = 0; k < 5; k++) begin
      d = (k == 3) ? 32'h04 : (k == 4) ? 32'h80 : 32'h44;
      wr(CTRL_ONE_ADDR, d);
      wr(CTRL_TWO_ADDR, (k == 2) ? 32'h40 : 32'h48);
      DBG_I <= (k == 1);
      cyc(6);
      chb(LOOP_O, k != 0 && k != 4);
    end
    DBG_I <= 1'b0;
    done("low power");
    // Stop keeps each reference only when allowed
    for (int k = 0; k < 4; k++) begin
      wr(CTRL_ONE_ADDR, {24'h0, STOP_C1[8*k +: 8]});
      wr(CTRL_TWO_ADDR, {24'h0, STOP_C2[8*k +: 8]});
      cyc(4);
      STOP_I <= 1'b1;
      cyc(4);
      chb(IRUN_O, STOP_INT[k]);
      chb(ERUN_O, STOP_EXT[k]);
      chb(LOOP_O, 1'b0);
      STOP_I <= 1'b0;
      cyc(2);
    end
    done("stop");
    final_report();
  end
endmodule // clock_source_control_regs_tb
